// *** hw/event_gen_pkg.sv ***
// package: constants, register map and carriers of the panel event generator
package event_gen_pkg;
    localparam int unsigned EVT_N = 48;
    localparam int unsigned GRP_N = 10;
    localparam int unsigned GRP_W = 16;
    localparam int unsigned PANEL_W = 160;
    localparam int unsigned TXT_CHARS = 32;
    localparam int unsigned TXT_WORDS = TXT_CHARS / 4;
    localparam int unsigned TXT_DEPTH = EVT_N * TXT_WORDS;
    // panel positions carrying a defined signal, bit n-1 for signal n
    localparam logic [159:0] DEF_MASK =
        160'h0000_0000_03FF_E000_0000_07FF_DC00_03F3_FF3F_BF9F;
    // panel signal numbers of the documented signal blocks
    localparam int unsigned SEQ_FIRST = 25;
    localparam int unsigned SEQ_LAST = 32;
    localparam int unsigned SWG_FIRST = 38;
    localparam int unsigned SWG_LAST = 42;
    localparam int unsigned FAIL_FIRST = 64;
    localparam int unsigned FAIL_LAST = 66;
    localparam int unsigned VOLT_FIRST = 110;
    localparam int unsigned VOLT_LAST = 122;
    localparam int unsigned VOLT_LOW_PCT = 50;
    localparam int unsigned VOLT_HIGH_PCT = 70;
    // timestamp tick of one millisecond at a 100 ns clock
    localparam int unsigned CLK_NS = 100;
    localparam int unsigned TICK_NS = 1000000;
    localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS = 8'h08;
    localparam logic [7:0] TIME_OFS = 8'h0C;
    localparam logic [7:0] SEL_OFS = 8'h10;
    localparam logic [7:0] CFG_OFS = 8'h14;
    localparam logic [7:0] REC_OFS = 8'h18;
    localparam logic [7:0] STAMP_OFS = 8'h1C;
    localparam logic [7:0] ACT0_OFS = 8'h20;
    localparam logic [7:0] ACT1_OFS = 8'h24;
    localparam logic [2:0] TXT_PAGE = 3'h2;
    // field positions
    localparam int unsigned EN_BIT = 0;
    localparam int unsigned CHG_BIT = 0;
    localparam int unsigned REJ_BIT = 1;
    localparam int unsigned GRP_LSB = 16;
    localparam int unsigned REC_STATE_BIT = 0;
    localparam int unsigned REC_ACK_BIT = 1;
    localparam int unsigned REC_LIVE_BIT = 2;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [3:0] group;
        logic [15:0] mask;
    } cfg_t;
endpackage : event_gen_pkg

// *** hw/status_panel_event_generator.sv ***
// status panel event generator: triggers, event records and apb registers
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
// Notes on behaviour
// - there are 48 event generators, each with its own trigger, text and record.
// - each trigger is an OR of up to 16 panel signals picked by a mask.
// - all picked signals come from one group, and a selection naming no valid group is refused.
// - any picked signal going active makes the trigger and its event active.
// - trigger and event go inactive once every picked signal is low, or when the enable bit is cleared.
// - each event holds a text of up to 32 characters.
// - an event record holds its text, an ack star, its state and its time stamp.
// - signals 110 to 122 are the phase and bus voltage threshold flags.
// - signals 25 to 32 report the control sequence state.
// - signals 38 to 42 report coupler breaker and earthing switch positions.
// - signals 64 to 66 report supply failures and the transformer protection trip.
// - the panel has 160 signals in 10 groups of 16, numbered from 1.
module status_panel_event_generator #(
    parameter int unsigned TICK_CYCLES = event_gen_pkg::TICK_CYC
)(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire event_gen_pkg::apb_req_t apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [event_gen_pkg::PANEL_W-1:0] panel_i,
    output logic [event_gen_pkg::EVT_N-1:0] event_active_o,
    output logic irq_o
);
    import event_gen_pkg::*;

    logic [PANEL_W-1:0] panel_meta_reg;
    logic [PANEL_W-1:0] panel_sync_reg;
    logic [PANEL_W-1:0] panel_live;
    cfg_t cfg_mem [EVT_N];
    logic [31:0] stamp_mem [EVT_N];
    logic [31:0] text_mem [TXT_DEPTH];
    logic [EVT_N-1:0] trig_now;
    logic [EVT_N-1:0] trig_reg;
    logic [EVT_N-1:0] ack_pend_reg;
    logic [EVT_N-1:0] chg;
    logic ctrl_en_reg;
    logic [1:0] sts_reg;
    logic [1:0] sts_next;
    logic [1:0] mask_reg;
    logic [1:0] mask_next;
    logic [5:0] sel_reg;
    logic [31:0] time_reg;
    logic [13:0] tick_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [31:0] rd_val;
    logic hit;
    logic setup;
    logic wr_ok;
    logic sel_ok;
    logic txt_hit;
    logic [8:0] txt_idx;
    logic cfg_wr;
    logic cfg_bad;
    logic ack_wr;

    // panel pins come from outside the clock domain
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            panel_meta_reg <= '0;
            panel_sync_reg <= '0;
        end else begin
            panel_meta_reg <= panel_i;
            panel_sync_reg <= panel_meta_reg;
        end
    end

    // undefined positions forced low; fixed layout of the panel
    assign panel_live = panel_sync_reg & DEF_MASK;

    // all 48 triggers evaluated in parallel every cycle
    always_comb begin
        for (int e = 0; e < EVT_N; e++) begin
            trig_now[e] = ctrl_en_reg
                && |(cfg_mem[e].mask & panel_live[cfg_mem[e].group * GRP_W +: GRP_W]);
        end
    end

    assign chg = trig_now ^ trig_reg;
    assign event_active_o = trig_reg;

    // apb access decode
    assign setup = apb_i.psel && !apb_i.penable;
    assign wr_ok = apb_i.psel && apb_i.penable && apb_i.pwrite && !pslverr_reg;
    assign sel_ok = sel_reg < 6'(EVT_N);
    assign txt_hit = apb_i.paddr[7:5] == TXT_PAGE && apb_i.paddr[1:0] == 2'h0;
    assign txt_idx = {sel_reg, apb_i.paddr[4:2]};
    assign cfg_wr = wr_ok && apb_i.paddr == CFG_OFS;
    assign cfg_bad = !sel_ok || apb_i.pwdata[GRP_LSB +: 4] >= 4'(GRP_N);
    assign ack_wr = wr_ok && apb_i.paddr == REC_OFS && sel_ok && apb_i.pwdata[REC_ACK_BIT];
    assign pready_o = 1'b1;
    assign prdata_o = prdata_reg;
    assign pslverr_o = pslverr_reg;

    // mask value after this cycle, so irq follows a mask write at once
    assign mask_next = (wr_ok && apb_i.paddr == MASK_OFS) ? apb_i.pwdata[1:0] : mask_reg;

    // read mux, address decode by if chain
    always_comb begin
        rd_val = 32'h0;
        hit = 1'b1;
        if (apb_i.paddr == CTRL_OFS) begin
            rd_val[EN_BIT] = ctrl_en_reg;
        end else if (apb_i.paddr == STS_OFS) begin
            rd_val[1:0] = sts_reg;
        end else if (apb_i.paddr == MASK_OFS) begin
            rd_val[1:0] = mask_reg;
        end else if (apb_i.paddr == TIME_OFS) begin
            rd_val = time_reg;
        end else if (apb_i.paddr == SEL_OFS) begin
            rd_val[5:0] = sel_reg;
        end else if (apb_i.paddr == CFG_OFS) begin
            rd_val[GRP_LSB +: 4] = sel_ok ? cfg_mem[sel_reg].group : 4'h0;
            rd_val[15:0] = sel_ok ? cfg_mem[sel_reg].mask : 16'h0;
        end else if (apb_i.paddr == REC_OFS) begin
            rd_val[REC_STATE_BIT] = sel_ok && trig_reg[sel_reg];
            rd_val[REC_ACK_BIT] = sel_ok && ack_pend_reg[sel_reg];
            rd_val[REC_LIVE_BIT] = sel_ok && trig_now[sel_reg];
        end else if (apb_i.paddr == STAMP_OFS) begin
            rd_val = sel_ok ? stamp_mem[sel_reg] : 32'h0;
        end else if (apb_i.paddr == ACT0_OFS) begin
            rd_val = trig_reg[31:0];
        end else if (apb_i.paddr == ACT1_OFS) begin
            rd_val[15:0] = trig_reg[47:32];
        end else if (txt_hit) begin
            rd_val = sel_ok ? text_mem[txt_idx] : 32'h0;
        end else begin
            hit = 1'b0;
        end
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg <= rd_val;
            pslverr_reg <= !hit;
        end
    end

    // control registers
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_en_reg <= 1'b0;
            mask_reg <= 2'h0;
            sel_reg <= 6'h0;
        end else if (wr_ok) begin
            if (apb_i.paddr == CTRL_OFS) begin
                ctrl_en_reg <= apb_i.pwdata[EN_BIT];
            end else if (apb_i.paddr == MASK_OFS) begin
                mask_reg <= apb_i.pwdata[1:0];
            end else if (apb_i.paddr == SEL_OFS) begin
                sel_reg <= apb_i.pwdata[5:0];
            end
        end
    end

    // trigger selections; a bad group or event index is refused
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int e = 0; e < EVT_N; e++) begin
                cfg_mem[e] <= '0;
            end
        end else if (cfg_wr && !cfg_bad) begin
            cfg_mem[sel_reg].group <= apb_i.pwdata[GRP_LSB +: 4];
            cfg_mem[sel_reg].mask <= apb_i.pwdata[15:0];
        end
    end

    // identification text, eight words of four characters each
    always_ff @(posedge sys_clk_i) begin
        if (wr_ok && txt_hit && sel_ok) begin
            text_mem[txt_idx] <= apb_i.pwdata;
        end
    end

    // millisecond time base, loadable by software
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_reg <= 14'h0;
            time_reg <= 32'h0;
        end else if (wr_ok && apb_i.paddr == TIME_OFS) begin
            tick_reg <= 14'h0;
            time_reg <= apb_i.pwdata;
        end else if (tick_reg == 14'(TICK_CYCLES - 1)) begin
            tick_reg <= 14'h0;
            time_reg <= time_reg + 32'h1;
        end else begin
            tick_reg <= tick_reg + 14'h1;
        end
    end

    // event records: state, ack star and stamp on every change
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            trig_reg <= '0;
            ack_pend_reg <= '0;
            for (int e = 0; e < EVT_N; e++) begin
                stamp_mem[e] <= 32'h0;
            end
        end else begin
            trig_reg <= trig_now;
            for (int e = 0; e < EVT_N; e++) begin
                if (chg[e]) begin
                    stamp_mem[e] <= time_reg;
                    ack_pend_reg[e] <= 1'b1;
                end else if (ack_wr && sel_reg == 6'(e)) begin
                    ack_pend_reg[e] <= 1'b0;
                end
            end
        end
    end

    // sticky status, write one to clear, set wins
    always_comb begin
        sts_next = sts_reg;
        if (wr_ok && apb_i.paddr == STS_OFS) begin
            sts_next = sts_reg & ~apb_i.pwdata[1:0];
        end
        if (|chg) begin
            sts_next[CHG_BIT] = 1'b1;
        end
        if (cfg_wr && cfg_bad) begin
            sts_next[REJ_BIT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sts_reg <= 2'h0;
            irq_o <= 1'b0;
        end else begin
            sts_reg <= sts_next;
            irq_o <= |(sts_next & mask_next);
        end
    end

    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_or_sets;
        ctrl_en_reg && |(cfg_mem[0].mask & panel_live[cfg_mem[0].group * GRP_W +: GRP_W]) |=> trig_reg[0];
    endproperty
    a_or_sets: assert property (p_or_sets) else $error("trigger missed active input");

    property p_all_low;
        trig_reg[0] && !trig_now[0] |=> !trig_reg[0] && ack_pend_reg[0];
    endproperty
    a_all_low: assert property (p_all_low) else $error("trigger did not fall");

    property p_stamp;
        $rose(trig_reg[0]) |-> stamp_mem[0] == $past(time_reg) && ack_pend_reg[0];
    endproperty
    a_stamp: assert property (p_stamp) else $error("rising event not stamped");

    property p_state_rec;
        chg != '0 |=> trig_reg == $past(trig_now) ##0 sts_reg[CHG_BIT];
    endproperty
    a_state_rec: assert property (p_state_rec) else $error("record state wrong");

    property p_undef;
        (panel_live & ~DEF_MASK) == '0;
    endproperty
    a_undef: assert property (p_undef) else $error("undefined position active");

    property p_reject;
        cfg_wr && cfg_bad |=> sts_reg[REJ_BIT] && $stable(cfg_mem[0]);
    endproperty
    a_reject: assert property (p_reject) else $error("bad selection stored");

    property p_mask_used;
        trig_now[0] |-> cfg_mem[0].mask != 16'h0 && cfg_mem[0].group < 4'(GRP_N);
    endproperty
    a_mask_used: assert property (p_mask_used) else $error("trigger without selection");

    property p_text;
        wr_ok && txt_hit && sel_ok |=> text_mem[$past(txt_idx)] == $past(apb_i.pwdata);
    endproperty
    a_text: assert property (p_text) else $error("text word not stored");

    property p_count;
        !sel_ok |-> sel_reg >= 6'(EVT_N);
    endproperty
    a_count: assert property (p_count) else $error("event index range wrong");

    property p_irq;
        sts_reg[CHG_BIT] && mask_reg[CHG_BIT] |-> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_ack_clear;
        ack_wr && !chg[sel_reg] |=> !ack_pend_reg[$past(sel_reg)];
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("ack star not cleared");

    property p_cfg_store;
        cfg_wr && !cfg_bad |=> cfg_mem[$past(sel_reg)].mask == $past(apb_i.pwdata[15:0])
            && cfg_mem[$past(sel_reg)].group == $past(apb_i.pwdata[GRP_LSB +: 4]);
    endproperty
    a_cfg_store: assert property (p_cfg_store) else $error("good selection not stored");

    property p_sync;
        panel_sync_reg == $past(panel_i, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("panel sync delay wrong");

    property p_time;
        tick_reg == 14'(TICK_CYCLES - 1) && !(wr_ok && apb_i.paddr == TIME_OFS) |=> time_reg == $past(time_reg) + 32'h1;
    endproperty
    a_time: assert property (p_time) else $error("time base did not advance");

    property p_irq_low;
        (sts_reg & mask_reg) == 2'h0 |-> !irq_o;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt without unmasked status");

    property p_sts_clear;
        wr_ok && apb_i.paddr == STS_OFS && apb_i.pwdata[CHG_BIT] && chg == '0 |=> !sts_reg[CHG_BIT];
    endproperty
    a_sts_clear: assert property (p_sts_clear) else $error("change status not cleared");

    property p_reject_sel;
        cfg_wr && !sel_ok |=> sts_reg[REJ_BIT];
    endproperty
    a_reject_sel: assert property (p_reject_sel) else $error("bad event index not flagged");

    property p_err_read;
        setup && !hit |=> pslverr_o;
    endproperty
    a_err_read: assert property (p_err_read) else $error("unmapped access not flagged");

    c_rise: cover property ($rose(trig_reg[0]));
    c_fall: cover property ($fell(trig_reg[0]));
    c_reject: cover property (cfg_wr && cfg_bad);
    c_ack: cover property (ack_wr && ack_pend_reg[sel_reg]);
    c_sel_range: cover property (cfg_wr && !sel_ok);
endmodule : status_panel_event_generator

// *** tb/panel_source_model.sv ***
// panel signal source standing in front of the event generator
`timescale 1ns/1ns
module panel_source_model (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] sig_num_i,
    input wire logic drive_i,
    input wire logic level_i,
    output logic [159:0] panel_o
);
    // holds each signal level until told otherwise, signal n on bit n-1
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            panel_o <= '0;
        end else if (drive_i) begin
            panel_o[sig_num_i - 8'h01] <= level_i;
        end
    end
endmodule : panel_source_model

// *** tb/test_status_panel_event_generator.sv ***
// self-checking bench of the status panel event generator
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module test_status_panel_event_generator;
    import event_gen_pkg::*;
    logic sys_clk_i;
    logic reset_n_i;
    apb_req_t apb_i;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [159:0] panel_i;
    logic [47:0] event_active_o;
    logic irq_o;
    logic [7:0] sig_num;
    logic sig_drive;
    logic sig_level;
    logic [31:0] rd;
    logic er;
    logic [7:0] v;
    logic [7:0] sigs [7];
    int err_total;
    int tests_run;

    status_panel_event_generator #(.TICK_CYCLES(4)) u_status_panel_event_generator (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .apb_i(apb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .panel_i(panel_i),
        .event_active_o(event_active_o), .irq_o(irq_o));
    panel_source_model u_panel_source_model (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .sig_num_i(sig_num),
        .drive_i(sig_drive), .level_i(sig_level), .panel_o(panel_i));

    // free running clock, 100 ns period
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task test_done;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done

    // one apb transfer: setup, access held until pready, then release
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        apb_i <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk_i);
        apb_i.penable <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        er = pslverr_o;
        apb_i <= '0;
        if (n >= 20) begin
            err_total++;
            test_done();
        end
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, ex, rd)
    endtask : rdchk

    // asks the panel model to move one signal
    task sig(input logic [7:0] n, input logic lv);
        @(posedge sys_clk_i);
        sig_num <= n;
        sig_level <= lv;
        sig_drive <= 1'b1;
        @(posedge sys_clk_i);
        sig_drive <= 1'b0;
    endtask : sig

    // bounded wait for one event output to reach a level, looked at on the falling edge
    task wait_evt(input int idx, input logic lv);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (event_active_o[idx] !== lv && n < 10);
        `CHK("event_active", lv, event_active_o[idx])
        if (n >= 10) test_done();
    endtask : wait_evt

    initial begin
        apb_i = '0;
        sig_num = 8'h01;
        sig_drive = 1'b0;
        sig_level = 1'b0;
        err_total = 0;
        tests_run = 0;
        sigs = '{8'h19, 8'h20, 8'h27, 8'h2A, 8'h40, 8'h42, 8'h7A};
        reset_n_i = 1'b0;
        repeat (16) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        rdchk("ctrl", CTRL_OFS, 32'h0000_0000);
        rdchk("status", STS_OFS, 32'h0000_0000);
        apb(1'b0, 8'h30, 32'h0000_0000);
        `CHK("unmapped_err", 1'b1, er)
        wr(MASK_OFS, 32'h0000_0003);
        wr(CTRL_OFS, 32'h0000_0001);
        $display("test reset done");
        // event 0 picks signals 35, 38 and 42 of the third group
        wr(SEL_OFS, 32'h0000_0000);
        wr(CFG_OFS, 32'h0002_0224);
        sig(8'h26, 1'b1);
        wait_evt(0, 1'b1);
        `CHK("irq", 1'b1, irq_o)
        rdchk("status", STS_OFS, 32'h0000_0001);
        rdchk("record", REC_OFS, 32'h0000_0007);
        sig(8'h2A, 1'b1);
        sig(8'h26, 1'b0);
        repeat (5) @(posedge sys_clk_i);
        `CHK("event_held", 1'b1, event_active_o[0])
        sig(8'h2A, 1'b0);
        wait_evt(0, 1'b0);
        rdchk("record", REC_OFS, 32'h0000_0002);
        wr(REC_OFS, 32'h0000_0002);
        rdchk("record_ack", REC_OFS, 32'h0000_0000);
        wr(MASK_OFS, 32'h0000_0000);
        repeat (2) @(posedge sys_clk_i);
        `CHK("irq_masked", 1'b0, irq_o)
        wr(MASK_OFS, 32'h0000_0003);
        wr(STS_OFS, 32'h0000_0001);
        repeat (2) @(posedge sys_clk_i);
        `CHK("irq_cleared", 1'b0, irq_o)
        sig(8'h23, 1'b1);
        repeat (5) @(posedge sys_clk_i);
        `CHK("undefined_quiet", 1'b0, event_active_o[0])
        sig(8'h23, 1'b0);
        $display("test trigger done");
        // group outside the panel is refused and leaves the old selection
        wr(CFG_OFS, 32'h000A_0001);
        rdchk("status_reject", STS_OFS, 32'h0000_0002);
        rdchk("cfg_kept", CFG_OFS, 32'h0002_0224);
        wr(STS_OFS, 32'h0000_0003);
        // empty selection for event 0, so signal 42 below moves only its own event
        wr(CFG_OFS, 32'h0000_0000);
        // documented signal blocks, one event for each of seven signals
        for (int i = 0; i < 7; i++) begin
            v = sigs[i] - 8'h01;
            wr(SEL_OFS, 32'(i + 10));
            wr(CFG_OFS, {12'h000, v[7:4], 16'h0001 << v[3:0]});
            sig(sigs[i], 1'b1);
            wait_evt(i + 10, 1'b1);
            rdchk("act0", ACT0_OFS, 32'h0000_0001 << (i + 10));
            sig(sigs[i], 1'b0);
            wait_evt(i + 10, 1'b0);
        end
        $display("test blocks done");
        // last event on a threshold flag, then an index past the end
        wr(SEL_OFS, 32'h0000_002F);
        wr(CFG_OFS, 32'h0006_2000);
        sig(8'h6E, 1'b1);
        wait_evt(47, 1'b1);
        rdchk("act1", ACT1_OFS, 32'h0000_8000);
        sig(8'h6E, 1'b0);
        wr(SEL_OFS, 32'h0000_0030);
        wr(STS_OFS, 32'h0000_0003);
        wr(CFG_OFS, 32'h0000_0001);
        rdchk("status_range", STS_OFS, 32'h0000_0002);
        rdchk("record_range", REC_OFS, 32'h0000_0000);
        $display("test range done");
        // stamp of a change against a loaded time, then enable off and on
        wr(SEL_OFS, 32'h0000_000A);
        wr(TIME_OFS, 32'h0000_1000);
        sig(8'h19, 1'b1);
        wait_evt(10, 1'b1);
        apb(1'b0, STAMP_OFS, 32'h0000_0000);
        `CHK("stamp", 1'b1, rd >= 32'h0000_1000 && rd <= 32'h0000_1002)
        apb(1'b0, TIME_OFS, 32'h0000_0000);
        `CHK("time_runs", 1'b1, rd > 32'h0000_1000)
        wr(CTRL_OFS, 32'h0000_0000);
        wait_evt(10, 1'b0);
        wr(CTRL_OFS, 32'h0000_0001);
        wait_evt(10, 1'b1);
        sig(8'h19, 1'b0);
        wait_evt(10, 1'b0);
        $display("test stamp done");
        // text words of one event
        wr(SEL_OFS, 32'h0000_0005);
        wr(8'h40, 32'h4142_4344);
        wr(8'h5C, 32'h5758_595A);
        rdchk("text_first", 8'h40, 32'h4142_4344);
        rdchk("text_last", 8'h5C, 32'h5758_595A);
        $display("test text done");
        test_done();
    end
endmodule : test_status_panel_event_generator
